/* File: hw/xbr_arbiter.sv */
// xbr_arbiter.sv: hand-over of the external bus to another master
// assumes hold and reclaim inputs synchronous to clk_i
`timescale 1ns/100ps
`include "xbr_regs.svh"
module xbr_arbiter (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // handshake
  input  wire logic hold_b_i,
  input  wire logic reclaim_want_i,
  input  wire logic cycle_busy_i,
  // state
  output logic      own_bus_o,
  output logic      bus_grant_ack_b_o,
  output logic      bus_reclaim_request_b_o
);
  xbr_pkg::xbr_arb_t st_q, st_d;
  logic ack_d, bus_reclaim_request_d;

  // next arbitration state
  always_comb begin
    st_d   = st_q;
    ack_d  = bus_grant_ack_b_o;
    bus_reclaim_request_d = bus_reclaim_request_b_o;
    case (st_q)
      xbr_pkg::XBR_OWN: begin
        if (!hold_b_i && !cycle_busy_i) begin
          st_d  = xbr_pkg::XBR_RELEASE;
          ack_d = 1'b0;
        end
      end
      xbr_pkg::XBR_RELEASE: begin
        st_d = xbr_pkg::XBR_HELD;
      end
      xbr_pkg::XBR_HELD: begin
        if (reclaim_want_i) begin
          bus_reclaim_request_d = 1'b0;
        end
        if (hold_b_i) begin
          st_d   = xbr_pkg::XBR_REGAIN;
          ack_d  = 1'b1;
          bus_reclaim_request_d = 1'b1;
        end
      end
      default: begin
        st_d = xbr_pkg::XBR_OWN;
      end
    endcase
  end

  // registers on bus clock edges
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q                    <= xbr_pkg::XBR_OWN;
      bus_grant_ack_b_o       <= 1'b1;
      bus_reclaim_request_b_o <= 1'b1;
      own_bus_o               <= 1'b1;
    end else begin
      st_q                    <= st_d;
      bus_grant_ack_b_o       <= ack_d;
      bus_reclaim_request_b_o <= bus_reclaim_request_d;
      own_bus_o               <= (st_d == xbr_pkg::XBR_OWN);
    end
  end

  a_ack_after_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(bus_grant_ack_b_o) |-> $past(!cycle_busy_i) && $past(!hold_b_i))
    else $error("acknowledge given during a running cycle");
  a_bus_reclaim_request_not_early: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(bus_reclaim_request_b_o) |-> $past(st_q) == xbr_pkg::XBR_HELD)
    else $error("reclaim request before release finished");
  a_regain_on_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(bus_grant_ack_b_o) |-> $past(hold_b_i))
    else $error("regain without hold returning high");
  a_regain_order: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(bus_grant_ack_b_o) |-> !own_bus_o ##1 own_bus_o)
    else $error("bus driven before acknowledge rose");
endmodule

/* File: hw/xbr_ctrl.sv */
// xbr_ctrl.sv: external bus cycle sequencer with ready, waitstates and arbitration
// assumes clk_i is the bus clock output and all inputs are synchronous to it
`timescale 1ns/100ps
`include "xbr_regs.svh"
// How it works
// - ready sampled high during a cycle adds a waitstate and samples again
// - ready sampled low ends the running bus cycle
// - cycle length follows programmed memory cycle waitstates, zero by default
// - strobe start depends on the programmed command delay option
// - multiplexed modes append turnaround waitstate, optional tristate waitstate too
// - multiplexed with tristate waitstate gives a two period gap
// - demultiplexed without tristate waitstate adds no gap
// - release request waits for the running cycle to finish
// - after release chip selects float, pulled high
// - reclaim request no earlier than the edge after release completes
// - regain starts only when release request returns high
// - reclaim request asserted before release ends is honoured
// - after regain the next own bus cycle may start
module xbr_ctrl (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  // configuration
  input  wire logic [`XBR_WS_W-1:0]    memory_cycle_waitstates_i,
  input  wire logic                    cmd_delay_i,
  input  wire logic                    mux_mode_i,
  input  wire logic                    tristate_waitstate_i,
  input  wire logic                    ready_en_i,
  // internal request
  input  wire logic                    req_i,
  input  wire logic                    req_write_i,
  input  wire logic [`XBR_CS_W-1:0]    req_cs_i,
  input  wire logic                    reclaim_want_i,
  output logic                         req_ack_o,
  output logic                         done_o,
  // bus pins
  input  wire logic                    ready_b_i,
  input  wire logic                    hold_b_i,
  output logic                         rd_b_o,
  output logic                         wr_b_o,
  output logic                         strobe_oe_o,
  output logic [`XBR_CS_W-1:0]         chip_select_outputs_o,
  output logic                         chip_select_oe_o,
  output logic                         bus_grant_ack_b_o,
  output logic                         bus_reclaim_request_b_o
);
  xbr_pkg::xbr_cyc_t      st_q, st_d;
  logic [`XBR_WS_W-1:0]   ws_q, ws_d;
  logic [2:0]             gap_q, gap_d;
  logic                   wr_q, wr_d;
  logic [`XBR_CS_W-1:0]   cs_d;
  logic                   rd_d, wrs_d, ack_d, done_d;
  logic                   own_bus, busy;

  // gap length after a cycle for the selected bus mode
  function automatic logic [2:0] gap_len(input logic mux, input logic tri_ws);
    if (mux && tri_ws) begin
      gap_len = `XBR_MUX_TRI_GAP;
    end else if (mux) begin
      gap_len = `XBR_MUX_GAP;
    end else if (tri_ws) begin
      gap_len = 3'h1;
    end else begin
      gap_len = 3'h0;
    end
  endfunction

  assign busy = (st_q != xbr_pkg::XBR_IDLE);

  xbr_arbiter u_arb (
    .clk_i                   (clk_i),
    .rst_b_i                 (rst_b_i),
    .hold_b_i                (hold_b_i),
    .reclaim_want_i          (reclaim_want_i),
    .cycle_busy_i            (busy || req_i),
    .own_bus_o               (own_bus),
    .bus_grant_ack_b_o       (bus_grant_ack_b_o),
    .bus_reclaim_request_b_o (bus_reclaim_request_b_o)
  );

  // next cycle state
  always_comb begin
    st_d   = st_q;
    ws_d   = ws_q;
    gap_d  = gap_q;
    wr_d   = wr_q;
    cs_d   = chip_select_outputs_o;
    rd_d   = 1'b1;
    wrs_d  = 1'b1;
    ack_d  = 1'b0;
    done_d = 1'b0;
    case (st_q)
      xbr_pkg::XBR_IDLE: begin
        cs_d = `XBR_CS_IDLE;
        if (req_i && own_bus && hold_b_i) begin
          ack_d = 1'b1;
          wr_d  = req_write_i;
          ws_d  = memory_cycle_waitstates_i;
          cs_d  = req_cs_i;
          if (cmd_delay_i) begin
            st_d = xbr_pkg::XBR_CMDDLY;
          end else begin
            st_d  = xbr_pkg::XBR_WAIT;
            rd_d  = req_write_i;
            wrs_d = !req_write_i;
          end
        end
      end
      xbr_pkg::XBR_CMDDLY: begin
        st_d  = xbr_pkg::XBR_WAIT;
        rd_d  = wr_q;
        wrs_d = !wr_q;
      end
      xbr_pkg::XBR_WAIT: begin
        rd_d  = wr_q;
        wrs_d = !wr_q;
        if (ws_q != '0) begin
          ws_d = ws_q - 1'b1;
        end else begin
          st_d = xbr_pkg::XBR_STROBE;
        end
      end
      xbr_pkg::XBR_STROBE: begin
        rd_d  = wr_q;
        wrs_d = !wr_q;
        if (!ready_en_i || !ready_b_i) begin
          rd_d   = 1'b1;
          wrs_d  = 1'b1;
          done_d = 1'b1;
          gap_d  = gap_len(mux_mode_i, tristate_waitstate_i);
          if (gap_len(mux_mode_i, tristate_waitstate_i) == 3'h0) begin
            st_d = xbr_pkg::XBR_IDLE;
            cs_d = `XBR_CS_IDLE;
          end else begin
            st_d = xbr_pkg::XBR_GAP;
          end
        end
      end
      default: begin
        if (gap_q <= 3'h1) begin
          st_d = xbr_pkg::XBR_IDLE;
          cs_d = `XBR_CS_IDLE;
        end else begin
          gap_d = gap_q - 3'h1;
        end
      end
    endcase
  end

  // registers, outputs straight from flip-flops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q                  <= xbr_pkg::XBR_IDLE;
      ws_q                  <= '0;
      gap_q                 <= 3'h0;
      wr_q                  <= 1'b0;
      rd_b_o                <= 1'b1;
      wr_b_o                <= 1'b1;
      chip_select_outputs_o <= `XBR_CS_IDLE;
      req_ack_o             <= 1'b0;
      done_o                <= 1'b0;
      strobe_oe_o           <= 1'b1;
      chip_select_oe_o      <= 1'b1;
    end else begin
      st_q                  <= st_d;
      ws_q                  <= ws_d;
      gap_q                 <= gap_d;
      wr_q                  <= wr_d;
      rd_b_o                <= rd_d;
      wr_b_o                <= wrs_d;
      chip_select_outputs_o <= cs_d;
      req_ack_o             <= ack_d;
      done_o                <= done_d;
      strobe_oe_o           <= own_bus;
      chip_select_oe_o      <= own_bus;
    end
  end

  a_ready_high_waits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == xbr_pkg::XBR_STROBE && ready_en_i && ready_b_i)
      |=> st_q == xbr_pkg::XBR_STROBE && !done_o)
    else $error("cycle ended while ready was high");
  a_ready_low_ends: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == xbr_pkg::XBR_STROBE && !ready_b_i) |=> done_o && rd_b_o && wr_b_o)
    else $error("cycle not ended by ready low");
  a_mux_tri_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (done_o && st_q == xbr_pkg::XBR_GAP && gap_q == 3'h2)
      |-> st_q == xbr_pkg::XBR_GAP ##1 st_q == xbr_pkg::XBR_GAP ##1 st_q == xbr_pkg::XBR_IDLE)
    else $error("multiplexed tristate gap not two periods");
  a_demux_no_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == xbr_pkg::XBR_STROBE && !ready_b_i && !mux_mode_i && !tristate_waitstate_i)
      |=> st_q == xbr_pkg::XBR_IDLE)
    else $error("demultiplexed cycle added a gap");
  a_cs_float: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !bus_grant_ack_b_o |=> !chip_select_oe_o)
    else $error("chip selects driven while bus released");
endmodule

/* File: hw/xbr_pkg.sv */
// xbr_pkg.sv: types for the external bus ready and arbitration block
// assumes no surroundings beyond the design files
package xbr_pkg;
  typedef enum logic [2:0] {
    XBR_IDLE   = 3'h0,
    XBR_CMDDLY = 3'h1,
    XBR_WAIT   = 3'h2,
    XBR_STROBE = 3'h3,
    XBR_GAP    = 3'h4
  } xbr_cyc_t;
  typedef enum logic [1:0] {
    XBR_OWN     = 2'h0,
    XBR_RELEASE = 2'h1,
    XBR_HELD    = 2'h2,
    XBR_REGAIN  = 2'h3
  } xbr_arb_t;
endpackage

/* File: hw/xbr_regs.svh */
// xbr_regs.svh: constants for the external bus ready and arbitration block
// assumes inclusion by the block's design files and its bench top
`ifndef XBR_REGS_SVH
`define XBR_REGS_SVH
// period of the bus clock output in ns
`define XBR_CLK_PERIOD_NS   5
// multiplexed gap with tristate waitstate, in bus clock periods
`define XBR_MUX_TRI_GAP     3'h2
// multiplexed gap without tristate waitstate
`define XBR_MUX_GAP         3'h1
// width of the memory cycle waitstate count
`define XBR_WS_W            4
// chip select count
`define XBR_CS_W            5
// idle value of chip selects
`define XBR_CS_IDLE         5'h1F
`endif

/* File: test/xbr_ctrl_tb_top.sv */
// xbr_ctrl_tb_top.sv: self-checking bench for the bus cycle sequencer
// assumes xbr_far_side answers ready and drives the release request
`timescale 1ns/100ps
`include "xbr_regs.svh"
module xbr_ctrl_tb_top;
  typedef struct {int len; int gap; logic [`XBR_CS_W-1:0] cs;} xbr_note_t;
  logic                 clk_i, rst_b_i, cmd, mux, tsw, ren, req, req_wr, reclaim;
  logic                 ack, done, ready_b, hold_b, rd_b, wr_b, soe, cs_oe, bus_grant_ack_b, bus_reclaim_request_b;
  logic                 hold_want;
  logic [`XBR_WS_W-1:0] ws;
  logic [`XBR_CS_W-1:0] req_cs, cs;
  logic [1:0]           dly;
  logic [31:0]          r;
  xbr_note_t            notes[$];
  int                   mismatches, compares, cyc, t_ack, t_done, seed, len, k;
  xbr_ctrl i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .memory_cycle_waitstates_i(ws),
    .cmd_delay_i(cmd), .mux_mode_i(mux), .tristate_waitstate_i(tsw), .ready_en_i(ren),
    .req_i(req), .req_write_i(req_wr), .req_cs_i(req_cs), .reclaim_want_i(reclaim),
    .req_ack_o(ack), .done_o(done), .ready_b_i(ready_b), .hold_b_i(hold_b), .rd_b_o(rd_b),
    .wr_b_o(wr_b), .strobe_oe_o(soe), .chip_select_outputs_o(cs), .chip_select_oe_o(cs_oe),
    .bus_grant_ack_b_o(bus_grant_ack_b), .bus_reclaim_request_b_o(bus_reclaim_request_b));
  xbr_far_side i_far (.clk_i(clk_i), .rd_b_i(rd_b), .wr_b_i(wr_b), .strobe_oe_i(soe),
    .ready_dly_i(dly), .hold_want_i(hold_want), .ready_b_o(ready_b), .hold_b_o(hold_b));
  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // note the expected cycle, raise the request and wait until it is taken
  task automatic issue(input int ln, input int gp);
    xbr_note_t n;
    int j;
    r = $random(seed);
    n.len = ln;
    n.gap = gp;
    n.cs = r[`XBR_CS_W-1:0];
    notes.push_back(n);
    req_cs <= n.cs;
    req_wr <= r[8];
    req <= 1'b1;
    j = 0;
    do begin
      @(posedge clk_i);
      j++;
    end while (ack !== 1'b1 && j < 60);
    // req stays up here; the caller lowers it, so a back-to-back call keeps it high without a gap
  endtask
  // watch taken requests and ended cycles against the oldest note
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      give_verdict();
    end
    if (ack === 1'b1 && notes.size() > 0) begin
      t_ack = cyc;
      check(cs === notes[0].cs, "chip select pattern");
      if (notes[0].gap >= 0) check(cyc - t_done == 1 + notes[0].gap, "gap");
    end
    if (done === 1'b1 && notes.size() > 0) begin
      check(cyc - t_ack == notes[0].len, "cycle length");
      void'(notes.pop_front());
      t_done = cyc;
    end
  end
  // main sequence
  initial begin
    {mismatches, compares, cyc, t_ack, t_done} = '0;
    seed = 13;
    rst_b_i = 1'b0;
    {cmd, mux, tsw, ren, req, req_wr, reclaim, hold_want} = '0;
    ws = '0;
    req_cs = `XBR_CS_IDLE;
    dly = '0;
    wclk(3);
    rst_b_i <= 1'b1;
    wclk(2);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      ws <= r[3:0];
      mux <= i[0];
      tsw <= i[1];
      cmd <= i[2];
      ren <= r[7] | r[6];
      dly <= r[10:9];
      len = 2 + i[2] + r[3:0];
      // ready is already seen after ws + 1 strobe edges, so only a longer delay stretches
      if ((r[7] | r[6]) && r[10:9] > r[3:0] + 1) len = len + r[10:9] - r[3:0] - 1;
      wclk(1);
      issue(len, -1);
      issue(len, i[0] ? (i[1] ? 2 : 1) : (i[1] ? 1 : 0));
      req <= 1'b0;
      k = 0;
      while (notes.size() > 0 && k < 80) begin
        wclk(1);
        k++;
      end
    end
    // release request during a cycle, with and without reclaim
    for (int j = 0; j < 2; j++) begin
      issue(len, -1);
      req <= 1'b0;
      hold_want <= 1'b1;
      k = 0;
      while (bus_grant_ack_b !== 1'b0 && k < 80) begin
        wclk(1);
        k++;
      end
      check(notes.size() == 0, "bus given up mid cycle");
      wclk(2);
      check(cs_oe === 1'b0 && soe === 1'b0 && cs === `XBR_CS_IDLE, "bus not floated");
      reclaim <= j[0];
      wclk(3);
      check(bus_reclaim_request_b === !j[0] && bus_grant_ack_b === 1'b0, "reclaim request");
      hold_want <= 1'b0;
      k = 0;
      while (bus_grant_ack_b !== 1'b1 && k < 6) begin
        wclk(1);
        k++;
      end
      check(bus_reclaim_request_b === 1'b1 && cs_oe === 1'b0, "regain order");
      reclaim <= 1'b0;
      // own flag settles one edge after ack, the enables one edge later
      wclk(2);
      check(cs_oe === 1'b1, "bus not driven again");
    end
    issue(len, -1);
    req <= 1'b0;
    wclk(60);
    check(notes.size() == 0, "cycle after regain");
    give_verdict();
  end
endmodule

/* File: test/xbr_far_side.sv */
// xbr_far_side.sv: ready-driving peripheral and external bus master
// assumes strobes sampled on clk_i, the bus clock output
`timescale 1ns/100ps
module xbr_far_side (
  // clock
  input  wire logic       clk_i,
  // device strobes
  input  wire logic       rd_b_i,
  input  wire logic       wr_b_i,
  input  wire logic       strobe_oe_i,
  // bench control
  input  wire logic [1:0] ready_dly_i,
  input  wire logic       hold_want_i,
  // answers
  output logic            ready_b_o,
  output logic            hold_b_o
);
  logic [1:0] cnt_q;
  logic       strb;
  assign strb = strobe_oe_i & ~(rd_b_i & wr_b_i);
  // count strobe cycles; ready stays high (pull-up) outside a strobe
  always_ff @(posedge clk_i) begin
    cnt_q <= strb ? ((cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1) : 2'h0;
  end
  // ready low after the delay, removed on the strobe's trailing edge
  assign ready_b_o = !(strb && cnt_q >= ready_dly_i);
  // master asks for and gives back the bus whenever told
  always_ff @(posedge clk_i) hold_b_o <= ~hold_want_i;
endmodule
